/* avg_divider.sv */
// Purpose: Iterative divider that turns a sample sum into its average.
// Assumes: Divisor is non-zero when start is raised.
// Notes:   One quotient bit per clock; start is ignored while busy.
`timescale 1ns/100ps
`default_nettype none
module avg_divider
   import map_sample_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             start,
   input  wire logic [SUM_W-1:0] dividend,
   input  wire logic [CNT_W-1:0] divisor,
   output logic                  busy,
   output logic                  done,
   output logic [P_W-1:0]        quotient
);

   logic [SUM_W-1:0] q_ff;
   logic [CNT_W:0]   rem_ff;
   logic [CNT_W-1:0] div_ff;
   logic [5:0]       step_ff;
   logic [CNT_W:0]   trial;
   logic             fits;

   // Shift the next dividend bit into the partial remainder and test it.
   assign trial = {rem_ff[CNT_W-1:0], q_ff[SUM_W-1]};
   assign fits  = trial >= {1'b0, div_ff};

   // Restoring division, most significant bit first.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q_ff    <= '0;
         rem_ff  <= '0;
         div_ff  <= '0;
         step_ff <= '0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!busy && start) begin
            q_ff    <= dividend;
            rem_ff  <= '0;
            div_ff  <= divisor;
            step_ff <= 6'(SUM_W);
            busy    <= 1'b1;
         end else if (busy) begin
            rem_ff  <= fits ? (trial - {1'b0, div_ff}) : trial;
            q_ff    <= {q_ff[SUM_W-2:0], fits};
            step_ff <= step_ff - 6'h01;
            if (step_ff == 6'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

   // An average never exceeds the largest sample, so the low bits suffice.
   assign quotient = q_ff[P_W-1:0];

endmodule
`default_nettype wire

/* engine_model.sv */
// Purpose: Crank, ignition and pressure source for the sampler.
// Assumes: One tick every two clocks, one sample between ticks.
// Notes:   Strokes alternate intake and power, starting with intake.
`timescale 1ns/100ps
`default_nettype none
module engine_model
   import map_sample_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             run,
   input  wire logic [ANG_W-1:0] dpe,
   input  wire logic [P_W-1:0]   lo,
   input  wire logic [P_W-1:0]   mid,
   input  wire logic [P_W-1:0]   hi,
   output logic                  sample_valid,
   output logic [P_W-1:0]        sample_data,
   output logic                  ign_event,
   output logic                  crank_tick
);
   logic             ph_ff, first_ff, intake_ff, sv_ff, ign_ff, tick_ff;
   logic [ANG_W-1:0] deg_ff;
   logic [P_W-1:0]   data_ff;
   // The dip sits around 130 to 170 degrees of the intake stroke only.
   wire in_dip = (deg_ff >= 10'd130) && (deg_ff < 10'd170);
   assign sample_valid = sv_ff;
   assign sample_data  = data_ff;
   assign ign_event    = ign_ff;
   assign crank_tick   = tick_ff;
   // Data is inverted when not valid so a stale value is never trusted.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {ph_ff, intake_ff, sv_ff, ign_ff, tick_ff} <= '0;
         first_ff <= 1'b1;
         deg_ff   <= '0;
         data_ff  <= '0;
      end else begin
         {sv_ff, ign_ff, tick_ff} <= '0;
         data_ff <= ~data_ff;
         if (run) begin
            ph_ff <= ~ph_ff;
            if (ph_ff && (first_ff || deg_ff == dpe - 10'd1)) begin
               ign_ff    <= 1'b1;
               deg_ff    <= '0;
               intake_ff <= first_ff | ~intake_ff;
               first_ff  <= 1'b0;
            end else if (ph_ff) begin
               tick_ff <= 1'b1;
               deg_ff  <= deg_ff + 10'd1;
            end else if (!first_ff) begin
               sv_ff   <= 1'b1;
               data_ff <= !intake_ff ? hi : (in_dip ? lo : mid);
            end
         end
      end
   end
endmodule
`default_nettype wire

/* manifold_pressure_sampler.sv */
// Purpose: Turns pressure samples into one load reading per ignition event.
// Assumes: Samples, ticks and events come from logic on ref_clk.
// Notes:   Registers sit on an AHB-Lite slave with zero wait states.
// Notes on behaviour
// - Averaging mode reports the mean of samples between two ignition events.
// - Window mode samples only inside the crank window and keeps the lowest.
// - Averaging mode ignores width, count, start curve and threshold settings.
// - Window opens at its start angle and closes after the width in degrees.
// - Report the running minimum over a group of windows for each window.
// - Start angle is degrees before TDC, kept below 720 over cylinders.
// - A window count of one reports each window's own minimum.
// - Enabled threshold compared to window pressure marks the intake stroke.
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
module manifold_pressure_sampler
   import map_sample_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // AHB-Lite slave.
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic [31:0]           hrdata,
   output logic                  hresp,
   // Engine position and sensor.
   input  wire logic             sample_valid,
   input  wire logic [P_W-1:0]   sample_data,
   input  wire logic             ign_event,
   input  wire logic             crank_tick,
   input  wire logic [RPM_W-1:0] engine_rpm,
   // Results.
   output logic [P_W-1:0]        map_reading,
   output logic                  reading_valid,
   output logic                  intake_stroke,
   output logic                  phase_valid
);

   // Configuration registers.
   logic                  mode_win_ff;
   logic                  phase_en_ff;
   logic [ANG_W-1:0]      width_ff;
   logic [WCNT_W-1:0]     wcount_ff;
   logic [CYL_W-1:0]      cyl_ff;
   logic [P_W-1:0]        thresh_ff;
   logic [RPM_W-1:0]      curve_rpm_ff [CURVE_N];
   logic [ANG_W-1:0]      curve_ang_ff [CURVE_N];
   // Bus state.
   logic                  wr_pend_ff;
   logic [AOFS_W-1:0]     wr_addr_ff;
   // Sampling state.
   logic [ANG_W-1:0]      deg_ff;
   win_state_t            ws_ff;
   win_state_t            nxt_ws;
   logic [P_W-1:0]        win_min_ff;
   logic [P_W-1:0]        grp_min_ff;
   logic [WCNT_W-1:0]     win_idx_ff;
   logic [SUM_W-1:0]      sum_ff;
   logic [CNT_W-1:0]      cnt_ff;
   logic                  clamp_ff;

   // Address phase decode.
   wire                   addr_phase = hsel & hready & htrans[HTRANS_ACT];
   wire                   rd_take    = addr_phase & ~hwrite;
   wire                   wr_take    = addr_phase & hwrite;
   wire [AOFS_W-1:0]      aofs       = haddr[AOFS_W-1:0];
   wire                   hi_zero    = (haddr[31:AOFS_W] == '0);

   // Curve slot decode shared by the read and write paths.
   function automatic logic curve_hit(
      input logic [AOFS_W-1:0] a,
      input logic [AOFS_W-1:0] base);
      return (a >= base) && (a < base + AOFS_W'(4 * CURVE_N))
             && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [1:0] curve_idx(
      input logic [AOFS_W-1:0] a,
      input logic [AOFS_W-1:0] base);
      logic [AOFS_W-1:0] d;
      d = a - base;
      return d[3:2];
   endfunction

   // Speed-indexed start angle: last breakpoint at or below engine speed.
   logic [ANG_W-1:0] curve_ang;
   always_comb begin
      curve_ang = curve_ang_ff[0];
      for (int i = 1; i < CURVE_N; i++) begin
         if (engine_rpm >= curve_rpm_ff[i]) begin
            curve_ang = curve_ang_ff[i];
         end
      end
   end

   // Window geometry; an oversize start is clamped to one degree short.
   wire [ANG_W-1:0]  dpe       = deg_per_event(cyl_ff);
   wire              start_ok  = curve_ang < dpe;
   wire [ANG_W-1:0]  eff_start = start_ok ? curve_ang
                                          : dpe - ANG_W'(1);
   wire [ANG_W-1:0]  open_pos  = dpe - eff_start;
   wire [ANG_W:0]    close_pos = {1'b0, open_pos} + {1'b0, width_ff};
   wire              at_open   = deg_ff >= open_pos;
   wire              at_close  = {1'b0, deg_ff} >= close_pos;
   localparam logic [WCNT_W-1:0] WCOUNT_W1 = 4'h1;
   wire [WCNT_W-1:0] grp_len   = (wcount_ff == '0) ? WCOUNT_W1 : wcount_ff;

   // Window closes at its width or at the next event, whichever is first.
   wire              closing   = mode_win_ff & (ws_ff == WS_OPEN)
                                 & (at_close | ign_event);
   wire [P_W-1:0]    cur_min   = (sample_valid && !ign_event)
                                 ? pmin(win_min_ff, sample_data)
                                 : win_min_ff;
   wire              grp_first = (win_idx_ff == '0);
   wire [P_W-1:0]    grp_next  = grp_first ? cur_min
                                           : pmin(grp_min_ff, cur_min);
   wire              grp_last  = (win_idx_ff + WCOUNT_W1) >= grp_len;

   // Window sequencer; it stays idle in averaging mode.
   always_comb begin
      nxt_ws = ws_ff;
      case (ws_ff)
         WS_WAIT: begin
            if (mode_win_ff && at_open && !ign_event) begin
               nxt_ws = WS_OPEN;
            end
         end
         WS_OPEN: begin
            if (closing) begin
               nxt_ws = ign_event ? WS_WAIT : WS_DONE;
            end
         end
         WS_DONE: begin
            if (ign_event) begin
               nxt_ws = WS_WAIT;
            end
         end
         default: nxt_ws = WS_WAIT;
      endcase
      if (!mode_win_ff) begin
         nxt_ws = WS_WAIT;
      end
   end

   // Crank degrees since the last ignition event, saturating.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         deg_ff <= '0;
      end else if (ign_event) begin
         deg_ff <= '0;
      end else if (crank_tick && deg_ff != '1) begin
         deg_ff <= deg_ff + ANG_W'(1);
      end
   end

   // Window minimum and group minimum tracking.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ws_ff      <= WS_WAIT;
         win_min_ff <= P_MAX;
         grp_min_ff <= P_MAX;
         win_idx_ff <= '0;
         clamp_ff   <= 1'b0;
      end else begin
         ws_ff <= nxt_ws;
         if (ws_ff == WS_WAIT && nxt_ws == WS_OPEN) begin
            win_min_ff <= (sample_valid) ? sample_data : P_MAX;
            clamp_ff   <= ~start_ok;
         end else if (ws_ff == WS_OPEN) begin
            win_min_ff <= cur_min;
         end
         if (closing) begin
            grp_min_ff <= grp_next;
            win_idx_ff <= grp_last ? '0 : win_idx_ff + WCOUNT_W1;
         end
         if (!mode_win_ff) begin
            win_idx_ff <= '0;
         end
      end
   end

   // Sum and count between ignition events; a sample with the event
   // belongs to the new interval, so none is counted twice.
   wire div_busy;
   wire div_done;
   wire [P_W-1:0] div_q;
   wire div_start = ign_event & ~mode_win_ff & (cnt_ff != '0);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sum_ff <= '0;
         cnt_ff <= '0;
      end else if (ign_event) begin
         sum_ff <= sample_valid ? SUM_W'(sample_data) : '0;
         cnt_ff <= sample_valid ? CNT_W'(1) : '0;
      end else if (sample_valid && cnt_ff != '1) begin
         sum_ff <= sum_ff + SUM_W'(sample_data);
         cnt_ff <= cnt_ff + CNT_W'(1);
      end
   end

   avg_divider u_div (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .start    (div_start),
      .dividend (sum_ff),
      .divisor  (cnt_ff),
      .busy     (div_busy),
      .done     (div_done),
      .quotient (div_q)
   );

   // Result outputs; averaging ignores every window setting.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         map_reading   <= '0;
         reading_valid <= 1'b0;
         intake_stroke <= 1'b0;
         phase_valid   <= 1'b0;
      end else begin
         reading_valid <= 1'b0;
         phase_valid   <= 1'b0;
         if (!mode_win_ff && div_done) begin
            map_reading   <= div_q;
            reading_valid <= 1'b1;
         end else if (closing) begin
            map_reading   <= grp_next;
            reading_valid <= 1'b1;
            if (phase_en_ff) begin
               intake_stroke <= cur_min < thresh_ff;
               phase_valid   <= 1'b1;
            end
         end
      end
   end

   // Register read mux, evaluated on the address phase.
   logic [31:0] rd_word;
   always_comb begin
      rd_word = '0;
      if (hi_zero) begin
         case (aofs)
            OFS_CTRL:   rd_word = 32'({phase_en_ff, mode_win_ff});
            OFS_WIDTH:  rd_word = 32'(width_ff);
            OFS_WCOUNT: rd_word = 32'(wcount_ff);
            OFS_CYL:    rd_word = 32'(cyl_ff);
            OFS_THRESH: rd_word = 32'(thresh_ff);
            OFS_STATUS: begin
               rd_word[P_W-1:0]      = map_reading;
               rd_word[ST_INTAKE_BIT] = intake_stroke;
               rd_word[ST_CLAMP_BIT]  = clamp_ff;
               rd_word[ST_OPEN_BIT]   = (ws_ff == WS_OPEN);
            end
            OFS_WINMIN: rd_word = 32'(win_min_ff);
            default: begin
               if (curve_hit(aofs, OFS_RPM0)) begin
                  rd_word = 32'(curve_rpm_ff[curve_idx(aofs, OFS_RPM0)]);
               end else if (curve_hit(aofs, OFS_ANG0)) begin
                  rd_word = 32'(curve_ang_ff[curve_idx(aofs, OFS_ANG0)]);
               end
            end
         endcase
      end
   end

   // Zero-wait slave: ready from the first clock after reset, and always OKAY.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hreadyout  <= 1'b0;
         hresp      <= 1'b0;
         hrdata     <= '0;
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= '0;
      end else begin
         hreadyout  <= 1'b1;
         wr_pend_ff <= wr_take & hi_zero;
         wr_addr_ff <= aofs;
         if (rd_take) begin
            hrdata <= rd_word;
         end
      end
   end

   // Data-phase writes; unmapped offsets and status are ignored.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_win_ff <= 1'b0;
         phase_en_ff <= 1'b0;
         width_ff    <= WIDTH_RST;
         wcount_ff   <= WCOUNT_RST;
         cyl_ff      <= CYL_RST;
         thresh_ff   <= THRESH_RST;
         for (int i = 0; i < CURVE_N; i++) begin
            curve_rpm_ff[i] <= '0;
            curve_ang_ff[i] <= ANG_RST;
         end
      end else if (wr_pend_ff) begin
         case (wr_addr_ff)
            OFS_CTRL: begin
               mode_win_ff <= hwdata[CTRL_MODE_BIT];
               phase_en_ff <= hwdata[CTRL_PHASE_BIT];
            end
            OFS_WIDTH:  width_ff  <= hwdata[ANG_W-1:0];
            OFS_WCOUNT: wcount_ff <= hwdata[WCNT_W-1:0];
            OFS_CYL:    cyl_ff    <= hwdata[CYL_W-1:0];
            OFS_THRESH: thresh_ff <= hwdata[P_W-1:0];
            default: begin
               if (curve_hit(wr_addr_ff, OFS_RPM0)) begin
                  curve_rpm_ff[curve_idx(wr_addr_ff, OFS_RPM0)]
                     <= hwdata[RPM_W-1:0];
               end else if (curve_hit(wr_addr_ff, OFS_ANG0)) begin
                  curve_ang_ff[curve_idx(wr_addr_ff, OFS_ANG0)]
                     <= hwdata[ANG_W-1:0];
               end
            end
         endcase
      end
   end

   // Transfer size and divider busy are not needed; only words are used.
   wire unused_ok = &{1'b0, hsize, div_busy};

endmodule
`default_nettype wire

/* map_sample_pkg.sv */
// Purpose: Shared constants and types for the manifold pressure sampler.
// Assumes: 12-bit pressure samples, one crank tick per degree.
// Notes:   Register offsets are byte addresses on the AHB-Lite slave.
package map_sample_pkg;

   // Data path widths.
   localparam int P_W     = 12;
   localparam int ANG_W   = 10;
   localparam int SUM_W   = 28;
   localparam int CNT_W   = 16;
   localparam int RPM_W   = 16;
   localparam int WCNT_W  = 4;
   localparam int CYL_W   = 4;
   localparam int CURVE_N = 4;
   localparam int AOFS_W  = 8;

   // Register byte offsets.
   localparam logic [AOFS_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [AOFS_W-1:0] OFS_WIDTH  = 8'h04;
   localparam logic [AOFS_W-1:0] OFS_WCOUNT = 8'h08;
   localparam logic [AOFS_W-1:0] OFS_CYL    = 8'h0C;
   localparam logic [AOFS_W-1:0] OFS_THRESH = 8'h10;
   localparam logic [AOFS_W-1:0] OFS_STATUS = 8'h14;
   localparam logic [AOFS_W-1:0] OFS_WINMIN = 8'h18;
   localparam logic [AOFS_W-1:0] OFS_RPM0   = 8'h20;
   localparam logic [AOFS_W-1:0] OFS_ANG0   = 8'h30;

   // Field positions.
   localparam int CTRL_MODE_BIT  = 0;
   localparam int CTRL_PHASE_BIT = 1;
   localparam int ST_INTAKE_BIT  = 12;
   localparam int ST_CLAMP_BIT   = 13;
   localparam int ST_OPEN_BIT    = 14;

   // Reset values.
   localparam logic [ANG_W-1:0]  WIDTH_RST  = 10'h03C;
   localparam logic [WCNT_W-1:0] WCOUNT_RST = 4'h1;
   localparam logic [CYL_W-1:0]  CYL_RST    = 4'h4;
   localparam logic [P_W-1:0]    THRESH_RST = 12'h800;
   localparam logic [ANG_W-1:0]  ANG_RST    = 10'h028;

   // Fixed figures.
   localparam logic [ANG_W-1:0] DEG_PER_CYCLE = 10'h2D0;
   localparam logic [P_W-1:0]   P_MAX         = 12'hFFF;
   localparam int               HTRANS_ACT    = 1;

   // Window sequencer states.
   typedef enum logic [2:0] {
      WS_WAIT = 3'b001,
      WS_OPEN = 3'b010,
      WS_DONE = 3'b100
   } win_state_t;

   // Degrees between ignition events; a zero count is taken as one cylinder.
   function automatic logic [ANG_W-1:0] deg_per_event(
      input logic [CYL_W-1:0] cyl);
      logic [ANG_W-1:0] c;
      c = (cyl == '0) ? ANG_W'(1) : ANG_W'(cyl);
      return DEG_PER_CYCLE / c;
   endfunction

   // Smaller of two samples.
   function automatic logic [P_W-1:0] pmin(
      input logic [P_W-1:0] a,
      input logic [P_W-1:0] b);
      return (a < b) ? a : b;
   endfunction

endpackage

/* mps_checker.sv */
// Purpose: Bus and result timing checks for the pressure sampler.
// Assumes: Only top ports are seen; the mode bit is snooped off the bus.
// Notes:   Bound into every instance of the sampler.
`timescale 1ns/100ps
`default_nettype none
module mps_checker
   import map_sample_pkg::*;
(
   input wire logic             ref_clk,
   input wire logic             rst,
   input wire logic             hsel,
   input wire logic [31:0]      haddr,
   input wire logic [1:0]       htrans,
   input wire logic             hwrite,
   input wire logic [2:0]       hsize,
   input wire logic [31:0]      hwdata,
   input wire logic             hready,
   input wire logic             hreadyout,
   input wire logic [31:0]      hrdata,
   input wire logic             hresp,
   input wire logic             sample_valid,
   input wire logic [P_W-1:0]   sample_data,
   input wire logic             ign_event,
   input wire logic             crank_tick,
   input wire logic [RPM_W-1:0] engine_rpm,
   input wire logic [P_W-1:0]   map_reading,
   input wire logic             reading_valid,
   input wire logic             intake_stroke,
   input wire logic             phase_valid
);
   logic wr_ctrl_ff;
   logic avg_ff;
   wire  take = hsel && hready && htrans[1];
   // Follow the mode bit, since latency differs between the two schemes.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_ctrl_ff <= 1'b0;
         avg_ff     <= 1'b1;
      end else begin
         wr_ctrl_ff <= take && hwrite && (haddr == 32'h0000_0000);
         if (wr_ctrl_ff)
            avg_ff <= !hwdata[CTRL_MODE_BIT];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_okay; hresp == 1'b0; endproperty
   property p_ready; !$past(rst) |-> hreadyout; endproperty
   property p_unmapped;
      take && !hwrite && (haddr[31:8] != 24'h00_0000) |=> hrdata == 0;
   endproperty
   property p_status;
      take && !hwrite && (haddr == 32'h0000_0014) |=>
         (hrdata[11:0] == $past(map_reading)) && (hrdata[31:15] == 0);
   endproperty
   property p_rv_pulse; reading_valid |=> !reading_valid; endproperty
   property p_pv_pulse; phase_valid |=> !phase_valid; endproperty
   property p_map_hold; !reading_valid |-> $stable(map_reading); endproperty
   property p_in_hold; !phase_valid |-> $stable(intake_stroke); endproperty
   // A wrong window close in averaging mode shows up as a stray report.
   property p_avg_lat;
      avg_ff && reading_valid |->
         ($past(ign_event, 30) || $past(ign_event, 31));
   endproperty
   a_okay: assert property (p_okay) else $error("hresp not OKAY");
   a_ready: assert property (p_ready) else $error("hreadyout low");
   a_unmapped: assert property (p_unmapped) else $error("unmapped data");
   a_status: assert property (p_status) else $error("status mismatch");
   a_rv_pulse: assert property (p_rv_pulse) else $error("valid long");
   a_pv_pulse: assert property (p_pv_pulse) else $error("phase long");
   a_map_hold: assert property (p_map_hold) else $error("map moved");
   a_in_hold: assert property (p_in_hold) else $error("intake moved");
   a_avg_lat: assert property (p_avg_lat) else $error("avg latency");
   c_avg: cover property (avg_ff && reading_valid);
   c_win: cover property (!avg_ff && reading_valid);
   c_intake: cover property (phase_valid && intake_stroke);
endmodule
bind manifold_pressure_sampler mps_checker mps_checker_inst (
   .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
   .hready, .hreadyout, .hrdata, .hresp, .sample_valid, .sample_data,
   .ign_event, .crank_tick, .engine_rpm, .map_reading, .reading_valid,
   .intake_stroke, .phase_valid);
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the manifold pressure sampler.
// Assumes: Zero-wait AHB-Lite slave, four cylinders, 180 degrees per event.
// Notes:   Each row is run from a fresh reset so groups start aligned.
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import map_sample_pkg::*;
;
   typedef struct {
      logic mode; logic [3:0] cnt; logic [9:0] wid; logic [15:0] rpm;
      logic [11:0] lo, mid; logic [3:0][11:0] ex;
   } row_t;
   logic ref_clk, rst, hsel, hwrite, run, sv, ign, tick, rv, pv, ist, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [15:0] rpm;
   logic [11:0] map, sd, lo, mid;
   wire hready;
   int num_errors, n_tests, k;
   logic [11:0] rq[$];
   logic iq[$];
   row_t rows[5];
   manifold_pressure_sampler manifold_pressure_sampler_inst (
      .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
      .sample_valid(sv), .sample_data(sd), .ign_event(ign),
      .crank_tick(tick), .engine_rpm(rpm), .map_reading(map),
      .reading_valid(rv), .intake_stroke(ist), .phase_valid(pv));
   engine_model engine_model_inst (
      .ref_clk(ref_clk), .rst(rst), .run(run), .dpe(10'd180), .lo(lo),
      .mid(mid), .hi(12'hE00), .sample_valid(sv), .sample_data(sd),
      .ign_event(ign), .crank_tick(tick));
   // Clock at 100 ns period.
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Collect every reported reading and phase decision.
   always @(posedge ref_clk) begin
      if (rv === 1'b1)
         rq.push_back(map);
      if (pv === 1'b1)
         iq.push_back(ist);
   end
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic end_of_test;
      if (num_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // One single transfer: address phase, then data phase, both held.
   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] q);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge ref_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hready !== 1'b1);
      q = hrdata;
      cmp_flag(hresp, 1'b0);
   endtask
   // The engine is already stopped by the caller, so run is left alone here.
   task automatic do_reset;
      rst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
   endtask
   initial begin
      {rst, hsel, hwrite, run, htrans, haddr, hwdata} = '0;
      rst = 1'b1;
      {rpm, lo, mid, num_errors, n_tests} = '0;
      rows[0] = '{1, 1, 20, 0, 12'h300, 12'h700,
                  {12'hE00, 12'h300, 12'hE00, 12'h300}};
      rows[1] = '{1, 2, 20, 0, 12'h300, 12'h700,
                  {12'h300, 12'h300, 12'h300, 12'h300}};
      rows[2] = '{0, 3, 700, 2000, 12'h300, 12'h300,
                  {12'hE00, 12'h300, 12'hE00, 12'h300}};
      rows[3] = '{1, 1, 200, 0, 12'h300, 12'h700,
                  {12'hE00, 12'h300, 12'hE00, 12'h300}};
      rows[4] = '{1, 1, 20, 2000, 12'h300, 12'h700,
                  {12'hE00, 12'h700, 12'hE00, 12'h700}};
      // Register reset values, and an alias write off the map.
      do_reset();
      ahb(1, 32'h0000_0104, 32'h0000_0005, rd);
      ahb(0, 32'h0000_0104, 0, rd);
      cmp_word(rd, 0);
      ahb(0, 32'h0000_0004, 0, rd);
      cmp_word(rd, 32'h0000_003C);
      ahb(0, 32'h0000_0008, 0, rd);
      cmp_word(rd, 32'h0000_0001);
      ahb(0, 32'h0000_000C, 0, rd);
      cmp_word(rd, 32'h0000_0004);
      ahb(0, 32'h0000_0010, 0, rd);
      cmp_word(rd, 32'h0000_0800);
      ahb(0, 32'h0000_0030, 0, rd);
      cmp_word(rd, 32'h0000_0028);
      foreach (rows[i]) begin
         do_reset();
         rq.delete();
         iq.delete();
         rpm <= rows[i].rpm;
         lo <= rows[i].lo;
         mid <= rows[i].mid;
         ahb(1, 32'h0000_0000, {30'h0, 1'b1, rows[i].mode}, rd);
         ahb(1, 32'h0000_0004, {22'h0, rows[i].wid}, rd);
         ahb(1, 32'h0000_0008, {28'h0, rows[i].cnt}, rd);
         ahb(1, 32'h0000_0024, 32'h0000_03E8, rd);
         ahb(1, 32'h0000_0028, 32'h0000_FFFF, rd);
         ahb(1, 32'h0000_002C, 32'h0000_FFFF, rd);
         ahb(1, 32'h0000_0034, 32'h0000_03FF, rd);
         run <= 1'b1;
         for (k = 0; k < 4000 && rq.size() < 4; k++)
            @(posedge ref_clk);
         run <= 1'b0;
         for (int j = 0; j < 4; j++) begin
            cmp_word({20'h0, rq[j]}, {20'h0, rows[i].ex[j]});
            if (rows[i].mode)
               cmp_flag(iq[j], j % 2 == 0);
         end
      end
      // Clamped start angle is flagged, and status ignores writes.
      ahb(1, 32'h0000_0014, 32'h0000_0000, rd);
      ahb(0, 32'h0000_0014, 0, rd);
      cmp_flag(rd[ST_CLAMP_BIT], 1'b1);
      // The last report of the clamped row is a power stroke window.
      cmp_word({20'h0, rd[11:0]}, 32'h0000_0E00);
      cmp_flag(rd[ST_INTAKE_BIT], 1'b0);
      end_of_test();
   end
   // Cut a hang short well past the expected run length.
   initial begin
      repeat (40000) @(posedge ref_clk);
      num_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
